// ---- design/bit_sync2.sv ----
// two-stage synchroniser for levels entering the aclk domain
module bit_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type s_q;
  sync_state_type s_d;

  always_comb
  begin
    s_d.meta = din;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stable;

endmodule

// ---- design/link_pkg.sv ----
// types for both ends of the status register link, each type used by one end only
package link_pkg;

  typedef logic [4:0][7:0] stat_bank_type;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_TAIL, H_GAP} host_state_type;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] opcode;
    logic [7:0] shift;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] rd_addr;
    logic frame_tgl;
  } link_state_type;

  typedef struct packed {
    stat_bank_type stat;
    logic wr_latch;
    logic vol_en;
    logic seen;
  } core_state_type;

  typedef struct packed {
    host_state_type st;
    logic [3:0] div;
    logic sck;
    logic cs_n;
    logic mosi;
    logic [63:0] shift;
    logic [6:0] left;
    logic [31:0] rx;
    logic [7:0] opcode;
    logic [2:0] nbytes;
    logic [2:0] xbits;
    logic [31:0] txd;
    logic [31:0] rxd;
    logic awready;
    logic aw_full;
    logic [7:0] awaddr;
    logic wready;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } host_reg_type;

endpackage

// ---- design/spi_link_if.sv ----
// serial link between the host controller and the status register device
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe_n;

  modport device (
    input cs_n,
    input sck,
    input mosi,
    output miso,
    output miso_oe_n
  );

  modport host (
    output cs_n,
    output sck,
    output mosi,
    input miso,
    input miso_oe_n
  );
endinterface

// ---- design/status_dev.sv ----
// status register device end: link shifter on sck, register bank on aclk
//
// Local design decision: the AXI4-Lite register port.
`include "status_link_params.svh"

module status_dev
  import link_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  spi_link_if.device link,
  output stat_bank_type status_bank,
  output logic write_enable_latch,
  output logic volatile_enable
);

  // ----------------------------------------
  // register bank helpers
  // ----------------------------------------
  function automatic logic [7:0] stat_read(input stat_bank_type bank, input logic latch, input logic [7:0] idx);
    logic [7:0] val;
    val = `STAT_UNDEF;
    if (idx >= `STAT_FIRST && idx <= `STAT_LAST) // RL2
    begin
      val = bank[idx[2:0] - 3'd1];
    end
    if (idx == `STAT_FIRST)
    begin
      val[`LATCH_BIT] = latch;
    end
    return val;
  endfunction

  function automatic stat_bank_type stat_write(input stat_bank_type bank, input logic [2:0] idx,
    input logic [7:0] val);
    stat_bank_type b;
    b = bank;
    if (idx == 3'd1)
    begin
      b[0] = (bank[0] & ~`SR1_WR_MASK) | (val & `SR1_WR_MASK);
    end
    else
    begin
      b[idx - 3'd1] = val;
    end
    return b;
  endfunction

  // ----------------------------------------
  // link domain (sck)
  // ----------------------------------------
  link_state_type lk_q;
  link_state_type lk_d;
  core_state_type c_q;
  core_state_type c_d;
  logic armed_q;
  logic miso_q;
  logic miso_oe_n_q;
  logic [7:0] sh;
  logic [2:0] cur_bit;
  logic [2:0] cur_byte;
  logic [7:0] out_byte;
  logic rd_drive;

  // armed while chip select is high, so the first edge of a frame restarts counting
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      armed_q <= 1'b1;
    end
    else
    begin
      armed_q <= 1'b0;
    end
  end

  always_comb
  begin
    lk_d = lk_q;
    cur_bit = lk_q.bit_cnt;
    cur_byte = lk_q.byte_cnt;
    if (armed_q)
    begin
      cur_bit = 3'd0;
      cur_byte = 3'd0;
      lk_d.frame_tgl = ~lk_q.frame_tgl;
    end
    sh = {lk_q.shift[6:0], link.mosi}; // RL7 RL14 RL16
    lk_d.shift = sh;
    if (cur_bit == 3'd7)
    begin
      lk_d.bit_cnt = 3'd0;
      lk_d.byte_cnt = (cur_byte == 3'd7) ? cur_byte : cur_byte + 3'd1;
      case (cur_byte)
        3'd0: lk_d.opcode = sh;
        3'd1:
        begin
          lk_d.byte1 = sh; // RL14
          lk_d.rd_addr = sh;
        end
        3'd2: lk_d.byte2 = sh; // RL16
        default: ;
      endcase
      if (cur_byte >= 3'd3 && lk_q.opcode == `OP_RD_IND)
      begin
        lk_d.rd_addr = lk_q.rd_addr + 8'h01; // RL18 RL3
      end
    end
    else
    begin
      lk_d.bit_cnt = cur_bit + 3'd1;
      lk_d.byte_cnt = cur_byte;
    end
  end

  // aresetn clears the whole link state, counters and frame toggle; the link is idle while it is low
  always_ff @(posedge link.sck or negedge aresetn)
  begin
    if (!aresetn)
    begin
      lk_q <= '0;
    end
    else
    begin
      lk_q <= lk_d;
    end
  end

  assign out_byte = stat_read(c_q.stat, c_q.wr_latch, lk_q.rd_addr);
  assign rd_drive = lk_q.opcode == `OP_RD_IND && lk_q.byte_cnt >= 3'd3;

  // read data goes out on the falling edge, one byte per eight clocks until release
  always_ff @(negedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
    end
    else
    begin
      miso_oe_n_q <= !rd_drive; // RL1
      // line held low while not driven, so write frames never leak register bits
      miso_q <= rd_drive && out_byte[3'd7 - lk_q.bit_cnt]; // RL1 RL7
    end
  end

  assign link.miso = miso_q;
  assign link.miso_oe_n = miso_oe_n_q;

  // ----------------------------------------
  // register domain (aclk)
  // ----------------------------------------
  logic cs_s;
  logic tgl_s;
  logic whole;
  logic [2:0] nb;

  bit_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({link.cs_n, lk_q.frame_tgl}),
    .dout({cs_s, tgl_s})
  );

  // frame fields are read only after release, when sck has stopped and they stand still
  always_comb
  begin
    c_d = c_q;
    whole = (lk_q.bit_cnt == 3'd0); // RL10
    nb = lk_q.byte_cnt;
    if (cs_s && tgl_s != c_q.seen)
    begin
      c_d.seen = tgl_s;
      if (whole && nb != 3'd0)
      begin
        case (lk_q.opcode)
          `OP_WR_ENABLE: c_d.wr_latch = 1'b1; // RL6
          `OP_VOL_ENABLE: c_d.vol_en = 1'b1; // RL5
          `OP_WR_SR1, `OP_WR_SR2, `OP_WR_SR3:
          begin
            if (nb >= 3'd2) // RL9
            begin
              if (c_q.wr_latch || c_q.vol_en) // RL5 RL19
              begin
                case (lk_q.opcode) // RL4
                  `OP_WR_SR1:
                  begin
                    c_d.stat = stat_write(c_q.stat, 3'd1, lk_q.byte1);
                    if (nb >= 3'd3)
                    begin
                      c_d.stat = stat_write(c_d.stat, 3'd2, lk_q.byte2); // RL11
                    end
                  end
                  `OP_WR_SR2: c_d.stat = stat_write(c_q.stat, 3'd2, lk_q.byte1);
                  default: c_d.stat = stat_write(c_q.stat, 3'd3, lk_q.byte1);
                endcase
              end
              c_d.wr_latch = 1'b0; // RL8
              c_d.vol_en = 1'b0; // RL5
            end
          end
          `OP_WR_IND:
          begin
            if (nb >= 3'd3) // RL9
            begin
              // RL13 RL15 RL17
              if (c_q.wr_latch && nb == 3'd3 && lk_q.byte1 >= `STAT_FIRST && lk_q.byte1 <= `STAT_LAST)
              begin
                c_d.stat = stat_write(c_q.stat, lk_q.byte1[2:0], lk_q.byte2); // RL12 RL16
              end
              c_d.wr_latch = 1'b0; // RL17
              c_d.vol_en = 1'b0; // RL5
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      c_q.stat <= {5{`STAT_RESET}};
      c_q.wr_latch <= 1'b0;
      c_q.vol_en <= 1'b0;
      c_q.seen <= 1'b0;
    end
    else
    begin
      c_q <= c_d;
    end
  end

  assign status_bank = c_q.stat;
  assign write_enable_latch = c_q.wr_latch;
  assign volatile_enable = c_q.vol_en;

endmodule

// ---- design/status_host.sv ----
// host controller end: AXI4-Lite command registers driving the serial link
`include "status_link_params.svh"

module status_host
  import link_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  spi_link_if.host link
);

  function automatic logic addr_ok(input logic [7:0] a);
    return a == `REG_CTRL || a == `REG_TXD || a == `REG_RXD || a == `REG_STAT;
  endfunction

  host_reg_type r_q;
  host_reg_type r_d;
  logic miso_s;

  bit_sync2 #(
    .WIDTH(1)
  ) u_miso_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(link.miso),
    .dout(miso_s)
  );

  always_comb
  begin
    r_d = r_q;
    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    if (awvalid && r_q.awready)
    begin
      r_d.aw_full = 1'b1;
      r_d.awready = 1'b0;
      r_d.awaddr = awaddr;
    end
    if (wvalid && r_q.wready)
    begin
      r_d.w_full = 1'b1;
      r_d.wready = 1'b0;
      r_d.wdata = wdata;
      r_d.wstrb = wstrb;
    end
    if (r_q.aw_full && r_q.w_full && !r_q.bvalid)
    begin
      r_d.aw_full = 1'b0;
      r_d.w_full = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = addr_ok(r_q.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (r_q.awaddr == `REG_TXD)
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (r_q.wstrb[i])
          begin
            r_d.txd[i*8 +: 8] = r_q.wdata[i*8 +: 8];
          end
        end
      end
      // a start while busy is dropped; software polls the busy bit first
      if (r_q.awaddr == `REG_CTRL && r_q.wstrb == 4'hF && r_q.st == H_IDLE)
      begin
        r_d.opcode = r_q.wdata[7:0];
        r_d.nbytes = r_q.wdata[`CTRL_NB_LSB +: 3];
        r_d.xbits = r_q.wdata[`CTRL_XB_LSB +: 3];
        if (r_q.wdata[`CTRL_GO])
        begin
          r_d.st = H_SHIFT;
          r_d.cs_n = 1'b0;
          r_d.sck = 1'b0;
          r_d.div = `SCK_HALF - 4'h1;
          r_d.shift = {r_q.wdata[7:0], r_q.txd, 24'h000000};
          r_d.mosi = r_q.wdata[7];
          r_d.left = 7'd8 + {1'b0, r_q.wdata[`CTRL_NB_LSB +: 3], 3'b000} + {4'b0000, r_q.wdata[`CTRL_XB_LSB +: 3]};
        end
      end
    end
    if (r_q.bvalid && bready)
    begin
      r_d.bvalid = 1'b0;
      r_d.awready = 1'b1;
      r_d.wready = 1'b1;
    end
    if (arvalid && r_q.arready)
    begin
      r_d.arready = 1'b0;
      r_d.rvalid = 1'b1;
      r_d.rresp = addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (araddr)
        `REG_CTRL: r_d.rdata = {17'h00000, r_q.xbits[2:0], 1'b0, r_q.nbytes, r_q.opcode};
        `REG_TXD: r_d.rdata = r_q.txd;
        `REG_RXD: r_d.rdata = r_q.rxd;
        `REG_STAT: r_d.rdata = {31'h00000000, r_q.st != H_IDLE};
        default: r_d.rdata = 32'h00000000;
      endcase
    end
    if (r_q.rvalid && rready)
    begin
      r_d.rvalid = 1'b0;
      r_d.arready = 1'b1;
    end
    // ----------------------------------------
    // serial shifter, sck divided from aclk
    // ----------------------------------------
    if (r_q.st != H_IDLE)
    begin
      if (r_q.div != 4'h0)
      begin
        r_d.div = r_q.div - 4'h1;
      end
      else
      begin
        r_d.div = `SCK_HALF - 4'h1;
        case (r_q.st)
          H_SHIFT:
          begin
            r_d.sck = ~r_q.sck;
            // sample late in the high phase: miso has settled through the synchroniser
            if (r_q.sck)
            begin
              r_d.rx = {r_q.rx[30:0], miso_s};
              r_d.left = r_q.left - 7'd1;
              r_d.shift = {r_q.shift[62:0], 1'b0};
              r_d.mosi = r_q.shift[62]; // RL7 RL14 RL16
              if (r_q.left == 7'd1)
              begin
                r_d.st = H_TAIL; // RL9 RL10
              end
            end
          end
          H_TAIL:
          begin
            r_d.cs_n = 1'b1;
            r_d.st = H_GAP;
            r_d.div = `CS_GAP - 4'h1;
          end
          H_GAP:
          begin
            r_d.rxd = r_q.rx;
            r_d.st = H_IDLE;
          end
          default: r_d.st = H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_q <= '0;
      r_q.st <= H_IDLE;
      r_q.cs_n <= 1'b1;
      r_q.awready <= 1'b1;
      r_q.wready <= 1'b1;
      r_q.arready <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign awready = r_q.awready;
  assign wready = r_q.wready;
  assign bvalid = r_q.bvalid;
  assign bresp = r_q.bresp;
  assign arready = r_q.arready;
  assign rvalid = r_q.rvalid;
  assign rdata = r_q.rdata;
  assign rresp = r_q.rresp;
  assign link.cs_n = r_q.cs_n;
  assign link.sck = r_q.sck;
  assign link.mosi = r_q.mosi;

endmodule

// ---- design/status_link_params.svh ----
// constants for the status register link: opcodes, layout, timing
//
// Operation
// RL1: indirect read streams up to 255 bytes; the code has no limit and streams until release
// RL2: registers 6 to 255 read as undefined
// RL3: read address wraps FFh to 00h, continues
// RL4: 01h/31h/11h write registers 1/2/3 directly
// RL5: 50h enables one following volatile status write
// RL6: host sends 06h before non-volatile writes
// RL7: opcode and data bytes shift MSB first
// RL8: direct write end clears write enable latch
// RL9: host sends whole command before release
// RL10: release off byte boundary aborts, no change
// RL11: 01h second data byte writes register 2
// RL12: 71h address 01h-05h selects register 1-5
// RL13: indirect write needs write enable latch set
// RL14: indirect address byte follows opcode, MSB first
// RL15: more than one indirect data byte writes nothing
// RL16: indirect data on clocks 16-23, MSB first
// RL17: bad indirect address aborts, latch cleared
// RL18: indirect read auto-increments register address
// RL19: no enable armed leaves registers unchanged
`ifndef STATUS_LINK_PARAMS_SVH
`define STATUS_LINK_PARAMS_SVH

`define OP_WR_ENABLE 8'h06
`define OP_VOL_ENABLE 8'h50
`define OP_WR_SR1 8'h01
`define OP_WR_SR2 8'h31
`define OP_WR_SR3 8'h11
`define OP_WR_IND 8'h71
`define OP_RD_IND 8'h65

`define STAT_RESET 8'h00
`define STAT_UNDEF 8'h00
`define LATCH_BIT 1
`define SR1_WR_MASK 8'hFC
`define STAT_FIRST 8'h01
`define STAT_LAST 8'h05

`define SCK_HALF 4'h4
`define CS_GAP 4'h8

`define REG_CTRL 8'h00
`define REG_TXD 8'h04
`define REG_RXD 8'h08
`define REG_STAT 8'h0C
`define CTRL_GO 31
`define CTRL_NB_LSB 8
`define CTRL_XB_LSB 12
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- testbench/status_link_props.sv ----
// protocol checker for the serial link between host and device ends
module status_link_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking link_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock moved with chip select high");
  sck_high_a: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("serial clock high phase not four cycles");
  sck_low_a: assert property ($fell(sck) |-> !sck [*4])
    else $error("serial clock low phase too short");
  mosi_hold_a: assert property ($rose(sck) |-> $stable(mosi) [*4])
    else $error("host data changed while clock high");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*5])
    else $error("chip select gap too short");
  cs_tail_a: assert property ($rose(cs_n) |-> !sck && $past(sck, 5))
    else $error("chip select released off the last clock tail");
  oe_idle_a: assert property (cs_n |-> miso_oe_n)
    else $error("device drives data without chip select");
  miso_idle_a: assert property (miso_oe_n |-> !miso)
    else $error("undriven data line not low");
  miso_hold_a: assert property ($rose(sck) && !miso_oe_n |-> $stable(miso) [*4])
    else $error("device data changed while clock high");
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench: host and device ends joined over the serial link
`include "status_link_params.svh"
module testbench import link_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk = 1'b0;
  logic aresetn = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wr_latch, vol_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  stat_bank_type bank;
  logic [7:0] exp_bank [5];
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  spi_link_if u_spi_link_if ();
  status_dev u_status_dev (.aclk(aclk), .aresetn(aresetn), .link(u_spi_link_if), .status_bank(bank),
    .write_enable_latch(wr_latch), .volatile_enable(vol_en));
  status_host u_status_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(u_spi_link_if));
  status_link_props u_status_link_props (.aclk(aclk), .aresetn(aresetn), .cs_n(u_spi_link_if.cs_n),
    .sck(u_spi_link_if.sck), .mosi(u_spi_link_if.mosi), .miso(u_spi_link_if.miso),
    .miso_oe_n(u_spi_link_if.miso_oe_n));

  always #25 aclk = ~aclk;

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic give_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      err_total = err_total + 1;
      give_verdict();
    end
  end

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // handshakes judged at the falling edge so the rising edge never races the design
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b)
    begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      if (b)
        bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    rv = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rv)
    begin
      @(negedge aclk);
      ar = arvalid && arready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar)
        arvalid <= 1'b0;
      if (rv)
        rready <= 1'b0;
    end
  endtask

  task automatic frame(input logic [7:0] op, input logic [2:0] nb, input logic [2:0] xb, input logic [31:0] tx);
    logic [1:0] r;
    logic [31:0] s;
    axi_wr(`REG_TXD, tx, r);
    axi_wr(`REG_CTRL, {1'b1, 16'h0, xb, 1'b0, nb, op}, r);
    s = 32'h1;
    while (s[0])
      axi_rd(`REG_STAT, s, r);
  endtask

  task automatic chk_bank;
    for (int k = 0; k < 5; k++)
      cmp_val({24'h0, bank[k]}, {24'h0, exp_bank[k]});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [1:0] r;
    logic [31:0] d;
    chk_bank();
    cmp_val({30'h0, wr_latch, vol_en}, 32'h0);
    axi_wr(8'h10, 32'h1234, r);
    cmp_val({30'h0, r}, {30'h0, `RESP_SLVERR});
    axi_rd(8'h10, d, r);
    cmp_val({30'h0, r}, {30'h0, `RESP_SLVERR});
    cmp_val(d, 32'h0);
    axi_wr(`REG_TXD, 32'hA5, r);
    axi_rd(`REG_TXD, d, r);
    cmp_val(d, 32'hA5);
  endtask

  task automatic t_direct;
    frame(`OP_WR_SR1, 3'h1, 3'h0, 32'hAA000000);
    chk_bank();
    frame(`OP_WR_ENABLE, 3'h0, 3'h0, 32'h0);
    cmp_val({30'h0, wr_latch, vol_en}, 32'h2);
    frame(`OP_WR_SR1, 3'h2, 3'h0, 32'hFF5A0000);
    exp_bank[0] = 8'hFF & `SR1_WR_MASK;
    exp_bank[1] = 8'h5A;
    chk_bank();
    cmp_val({31'h0, wr_latch}, 32'h0);
    frame(`OP_WR_ENABLE, 3'h0, 3'h0, 32'h0);
    frame(`OP_WR_SR3, 3'h1, 3'h0, 32'h3C000000);
    exp_bank[2] = 8'h3C;
    chk_bank();
  endtask

  task automatic t_volatile;
    frame(`OP_VOL_ENABLE, 3'h0, 3'h0, 32'h0);
    cmp_val({30'h0, wr_latch, vol_en}, 32'h1);
    frame(`OP_WR_SR2, 3'h1, 3'h0, 32'h33000000);
    exp_bank[1] = 8'h33;
    chk_bank();
    cmp_val({31'h0, vol_en}, 32'h0);
    frame(`OP_WR_SR2, 3'h1, 3'h0, 32'h44000000);
    chk_bank();
  endtask

  task automatic t_indirect;
    logic [7:0] bad [3] = '{8'h00, 8'h06, 8'hFF};
    logic [7:0] v;
    for (int k = 1; k <= 5; k++)
    begin
      v = 8'hB0 | k[7:0];
      frame(`OP_WR_ENABLE, 3'h0, 3'h0, 32'h0);
      frame(`OP_WR_IND, 3'h2, 3'h0, {k[7:0], v, 16'h0});
      exp_bank[k - 1] = (k == 1) ? (v & `SR1_WR_MASK) : v;
      chk_bank();
    end
    frame(`OP_WR_IND, 3'h2, 3'h0, 32'h04EE0000);
    chk_bank();
    foreach (bad[i])
    begin
      frame(`OP_WR_ENABLE, 3'h0, 3'h0, 32'h0);
      frame(`OP_WR_IND, 3'h2, 3'h0, {bad[i], 24'h770000});
      chk_bank();
      cmp_val({31'h0, wr_latch}, 32'h0);
    end
    frame(`OP_WR_ENABLE, 3'h0, 3'h0, 32'h0);
    frame(`OP_WR_IND, 3'h3, 3'h0, 32'h02112200);
    chk_bank();
  endtask

  task automatic t_read;
    logic [1:0] r;
    logic [31:0] d;
    frame(`OP_RD_IND, 3'h7, 3'h0, 32'h01000000);
    axi_rd(`REG_RXD, d, r);
    cmp_val(d, {exp_bank[1], exp_bank[2], exp_bank[3], exp_bank[4]});
    frame(`OP_RD_IND, 3'h7, 3'h0, 32'h02000000);
    axi_rd(`REG_RXD, d, r);
    cmp_val(d, {exp_bank[2], exp_bank[3], exp_bank[4], `STAT_UNDEF});
    frame(`OP_RD_IND, 3'h3, 3'h0, 32'h06000000);
    axi_rd(`REG_RXD, d, r);
    cmp_val({24'h0, d[7:0]}, {24'h0, `STAT_UNDEF});
    frame(`OP_RD_IND, 3'h5, 3'h0, 32'hFF000000);
    axi_rd(`REG_RXD, d, r);
    cmp_val({8'h0, d[23:0]}, {8'h0, `STAT_UNDEF, `STAT_UNDEF, exp_bank[0]});
  endtask

  task automatic t_abort;
    frame(`OP_WR_ENABLE, 3'h0, 3'h0, 32'h0);
    frame(`OP_WR_SR1, 3'h1, 3'h3, 32'h12000000);
    chk_bank();
    cmp_val({31'h0, wr_latch}, 32'h1);
  endtask

  initial
  begin
    // a real falling edge, so the link side's asynchronous clear takes effect
    aresetn <= 1'b0;
    for (int k = 0; k < 5; k++)
      exp_bank[k] = `STAT_RESET;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_direct();
    t_volatile();
    t_indirect();
    t_read();
    t_abort();
    give_verdict();
  end
endmodule
